// File: hdl/pteu_defines.vh
// Constants for the eight-channel pin task and event unit.
// Assumes a 12-bit APB byte address and a 32-pin general purpose port.
`ifndef PTEU_DEFINES_VH
`define PTEU_DEFINES_VH

// Unit shape.
`define PTEU_NCH          8
`define PTEU_NPIN         32
`define PTEU_STRIDE       12'h004

// Register byte offsets.
`define PTEU_OFF_OUT      12'h000
`define PTEU_OFF_SET      12'h030
`define PTEU_OFF_CLR      12'h060
`define PTEU_OFF_EVIN     12'h100
`define PTEU_OFF_EVPORT   12'h17c
`define PTEU_OFF_CFG      12'h510
`define PTEU_OFF_WAKESEL  12'h600
`define PTEU_OFF_LATCH    12'h604
`define PTEU_OFF_PINLVL   12'h608

// Channel setup register fields.
`define PTEU_CFG_MODE     1:0
`define PTEU_CFG_PSEL     12:8
`define PTEU_CFG_POL      17:16
`define PTEU_CFG_INIT     20
`define PTEU_CFG_MASK     32'h0013_1f03
`define PTEU_CFG_RESET    32'h0000_0000

// Mode encodings.
`define PTEU_MODE_EVENT   2'h1
`define PTEU_MODE_TASK    2'h3

// Action / edge encodings.
`define PTEU_POL_NONE     2'h0
`define PTEU_POL_HIGH     2'h1
`define PTEU_POL_LOW      2'h2
`define PTEU_POL_TOGGLE   2'h3

// Pin sense encodings.
`define PTEU_SENSE_HIGH   2'h2
`define PTEU_SENSE_LOW    2'h3

`endif

// File: hdl/pteu_pin_task_event_unit.v
// Eight-channel pin task and event unit with an APB register slave.
// Assumes the ordinary pin port supplies its output and direction values
// and its per-pin sense fields; pad inputs arrive asynchronously.
`default_nettype none
`include "pteu_defines.vh"

module pteu_pin_task_event_unit (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] padIn,
    input  wire [31:0] portOutValue,
    input  wire [31:0] portDirOut,
    input  wire [63:0] padSense,
    output reg  [31:0] padOut,
    output reg  [31:0] padOe,
    input  wire [7:0]  fabricSetTask,
    input  wire [7:0]  drive_low_task,
    input  wire [7:0]  fabricOutTask,
    output reg  [7:0]  eventInPulse,
    output reg         portEventPulse,
    input  wire        systemOffReq,
    output reg         wakeReset,
    output reg         wakeLine
);

    // Bus strobes: a write takes effect on the completing access edge.
    wire        wrEn   = psel & penable & pready & pwrite;
    wire        setupC = psel & ~penable;

    // Pad synchroniser stages and debounced level.
    reg  [31:0] sync1_q;
    reg  [31:0] sync2_q;
    reg  [31:0] sync3_q;
    reg  [31:0] pinLvl_q;
    reg  [31:0] pinPrev_q;
    wire [31:0] pinLvl_d;

    // Flattened per-channel state for the shared muxes.
    wire [255:0] cfgAll;
    wire [7:0]   levelAll;
    wire [7:0]   evFlagAll;
    wire [7:0]   evHitAll;
    wire [39:0]  selAll;
    wire [15:0]  modeAll;

    // Wake line sources.
    reg         wakeSel_q;
    reg  [31:0] latch_q;
    reg         portFlag_q;
    reg  [31:0] senseMatch;
    wire        latchClr = wrEn & (paddr == `PTEU_OFF_LATCH);
    wire        wakeRaw;

    // Three-stage pad capture; a level counts once stages two and three agree.
    always @(posedge clk) begin
        if (sys_rst) begin
            sync1_q   <= 32'h0000_0000;
            sync2_q   <= 32'h0000_0000;
            sync3_q   <= 32'h0000_0000;
            pinLvl_q  <= 32'h0000_0000;
            pinPrev_q <= 32'h0000_0000;
        end else begin
            sync1_q   <= padIn;
            sync2_q   <= sync1_q;
            sync3_q   <= sync2_q;
            pinLvl_q  <= pinLvl_d;
            pinPrev_q <= pinLvl_q;
        end
    end

    assign pinLvl_d = (sync2_q & sync3_q) | (pinLvl_q & (sync2_q ^ sync3_q));

    // Per-channel setup register, pin level and input event logic.
    genvar n;
    generate
        for (n = 0; n < `PTEU_NCH; n = n + 1) begin : gCh
            // Channel offset kept at full width, then cut to the bus width.
            localparam [31:0] OFS   = `PTEU_STRIDE * n;
            localparam [11:0] A_OUT = `PTEU_OFF_OUT + OFS[11:0];
            localparam [11:0] A_SET = `PTEU_OFF_SET + OFS[11:0];
            localparam [11:0] A_CLR = `PTEU_OFF_CLR + OFS[11:0];
            localparam [11:0] A_EV  = `PTEU_OFF_EVIN + OFS[11:0];
            localparam [11:0] A_CFG = `PTEU_OFF_CFG + OFS[11:0];

            reg  [31:0] cfg_q;
            reg         level_q;
            reg         evFlag_q;
            wire [1:0]  mode   = cfg_q[`PTEU_CFG_MODE];
            wire [1:0]  pol    = cfg_q[`PTEU_CFG_POL];
            wire [4:0]  sel    = cfg_q[`PTEU_CFG_PSEL];
            wire        cfgWr  = wrEn & (paddr == A_CFG);
            wire        toTask = pwdata[`PTEU_CFG_MODE] == `PTEU_MODE_TASK;
            // Software strobes and fabric strobes merge into one pulse.
            wire outStb = fabricOutTask[n]
                        | (wrEn & (paddr == A_OUT) & pwdata[0]);
            wire setStb = fabricSetTask[n]
                        | (wrEn & (paddr == A_SET) & pwdata[0]);
            wire clrStb = drive_low_task[n]
                        | (wrEn & (paddr == A_CLR) & pwdata[0]);
            wire cur    = pinLvl_q[sel];
            wire prev   = pinPrev_q[sel];
            reg         hit;

            // The setup register holds all controls of the channel.
            always @(posedge clk) begin
                if (sys_rst) begin
                    cfg_q <= `PTEU_CFG_RESET;
                end else if (cfgWr) begin
                    cfg_q <= pwdata & `PTEU_CFG_MASK;
                end
            end

            // Output level; the configurable task outranks drive-low,
            // which outranks drive-high, and action none swallows both.
            always @(posedge clk) begin
                if (sys_rst) begin
                    level_q <= 1'b0;
                end else if (cfgWr & toTask) begin
                    level_q <= pwdata[`PTEU_CFG_INIT];
                end else if (mode == `PTEU_MODE_TASK) begin
                    if (outStb) begin
                        case (pol)
                            `PTEU_POL_HIGH:   level_q <= 1'b1;
                            `PTEU_POL_LOW:    level_q <= 1'b0;
                            `PTEU_POL_TOGGLE: level_q <= ~level_q;
                            default:          level_q <= level_q;
                        endcase
                    end else if (clrStb) begin
                        level_q <= 1'b0;
                    end else if (setStb) begin
                        level_q <= 1'b1;
                    end
                end
            end

            // Edge condition on the bound pin in event mode.
            always @* begin
                hit = 1'b0;
                if (mode == `PTEU_MODE_EVENT) begin
                    case (pol)
                        `PTEU_POL_HIGH:   hit = cur & ~prev;
                        `PTEU_POL_LOW:    hit = ~cur & prev;
                        `PTEU_POL_TOGGLE: hit = cur ^ prev;
                        default:          hit = 1'b0;
                    endcase
                end
            end

            // Sticky event flag; a new event wins over a clearing write.
            always @(posedge clk) begin
                if (sys_rst) begin
                    evFlag_q <= 1'b0;
                end else if (hit) begin
                    evFlag_q <= 1'b1;
                end else if (wrEn & (paddr == A_EV) & ~pwdata[0]) begin
                    evFlag_q <= 1'b0;
                end
            end

            // Flattened copies feed the shared pad mux, the read decode and the input event pulses.
            assign cfgAll[n*32 +: 32] = cfg_q;
            assign levelAll[n]        = level_q;
            assign evFlagAll[n]       = evFlag_q;
            assign evHitAll[n]        = hit;
            assign selAll[n*5 +: 5]   = sel;
            assign modeAll[n*2 +: 2]  = mode;
        end
    endgenerate

    // Pad override: channels take pins from the ordinary port by mode.
    reg [31:0] padOut_d;
    reg [31:0] padOe_d;
    integer p;
    integer c;
    always @* begin
        padOut_d = portOutValue;
        padOe_d  = portDirOut;
        for (p = 0; p < `PTEU_NPIN; p = p + 1) begin
            for (c = 0; c < `PTEU_NCH; c = c + 1) begin
                if (selAll[c*5 +: 5] == p[4:0]) begin
                    if (modeAll[c*2 +: 2] == `PTEU_MODE_TASK) begin
                        padOut_d[p] = levelAll[c];
                        padOe_d[p]  = 1'b1;
                    end else if (modeAll[c*2 +: 2] == `PTEU_MODE_EVENT) begin
                        padOe_d[p]  = 1'b0;
                    end
                end
            end
        end
    end

    // Per-pin sense match against the ordinary port's sense fields.
    integer s;
    always @* begin
        senseMatch = 32'h0000_0000;
        for (s = 0; s < `PTEU_NPIN; s = s + 1) begin
            senseMatch[s] = ((padSense[s*2 +: 2] == `PTEU_SENSE_HIGH)
                             & pinLvl_q[s])
                          | ((padSense[s*2 +: 2] == `PTEU_SENSE_LOW)
                             & ~pinLvl_q[s]);
        end
    end

    // Latched sense record; write one clears, a live match wins.
    always @(posedge clk) begin
        if (sys_rst) begin
            latch_q   <= 32'h0000_0000;
            wakeSel_q <= 1'b0;
        end else begin
            latch_q <= senseMatch
                     | (latch_q & ~(latchClr ? pwdata : 32'h0000_0000));
            if (wrEn & (paddr == `PTEU_OFF_WAKESEL)) begin
                wakeSel_q <= pwdata[0];
            end
        end
    end

    // Wake source: live sense matches, or the latched record when chosen.
    // It needs no request of any kind and keeps running while all is idle.
    assign wakeRaw = wakeSel_q ? |latch_q : |senseMatch;

    // Wake line and port event. A latch clear with the record chosen drops the line for one
    // cycle so bits still set after it give a fresh rising edge.
    always @(posedge clk) begin
        if (sys_rst) begin
            wakeLine       <= 1'b0;
            portEventPulse <= 1'b0;
            portFlag_q     <= 1'b0;
            wakeReset      <= 1'b0;
        end else begin
            wakeLine       <= (latchClr & wakeSel_q) ? 1'b0
                                                     : wakeRaw;
            portEventPulse <= wakeRaw & ~wakeLine & ~(latchClr & wakeSel_q);
            if (wakeRaw & ~wakeLine & ~(latchClr & wakeSel_q)) begin
                portFlag_q <= 1'b1;
            end else if (wrEn & (paddr == `PTEU_OFF_EVPORT) & ~pwdata[0]) begin
                portFlag_q <= 1'b0;
            end
            wakeReset <= systemOffReq & wakeLine;
        end
    end

    // Read decode; task registers read as zero.
    reg  [31:0] rdData;
    reg         addrHit;
    integer     r;
    always @* begin
        rdData  = 32'h0000_0000;
        addrHit = 1'b0;
        for (r = 0; r < `PTEU_NCH; r = r + 1) begin
            if (paddr == `PTEU_OFF_OUT + `PTEU_STRIDE * r ||
                paddr == `PTEU_OFF_SET + `PTEU_STRIDE * r ||
                paddr == `PTEU_OFF_CLR + `PTEU_STRIDE * r) begin
                addrHit = 1'b1;
            end
            if (paddr == `PTEU_OFF_EVIN + `PTEU_STRIDE * r) begin
                addrHit = 1'b1;
                rdData  = {31'h0000_0000, evFlagAll[r]};
            end
            if (paddr == `PTEU_OFF_CFG + `PTEU_STRIDE * r) begin
                addrHit = 1'b1;
                rdData  = cfgAll[r*32 +: 32];
            end
        end
        case (paddr)
            `PTEU_OFF_EVPORT: begin
                addrHit = 1'b1;
                rdData  = {31'h0000_0000, portFlag_q};
            end
            `PTEU_OFF_WAKESEL: begin
                addrHit = 1'b1;
                rdData  = {31'h0000_0000, wakeSel_q};
            end
            `PTEU_OFF_LATCH: begin
                addrHit = 1'b1;
                rdData  = latch_q;
            end
            `PTEU_OFF_PINLVL: begin
                addrHit = 1'b1;
                rdData  = pinLvl_q;
            end
            default: begin
                addrHit = addrHit;
            end
        endcase
    end

    // APB answer: ready in the first access cycle, data taken at setup.
    always @(posedge clk) begin
        if (sys_rst) begin
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            prdata       <= 32'h0000_0000;
            padOut       <= 32'h0000_0000;
            padOe        <= 32'h0000_0000;
            eventInPulse <= 8'h00;
        end else begin
            pready       <= setupC;
            pslverr      <= setupC & ~addrHit;
            prdata       <= setupC & ~pwrite ? rdData : 32'h0000_0000;
            padOut       <= padOut_d;
            padOe        <= padOe_d;
            eventInPulse <= evHitAll;
        end
    end

endmodule
`default_nettype wire

// File: testbench/ptec_pads.sv
// Partner model: the outside circuitry on the general purpose pins.
// Assumes pad drive and enable come straight from the unit.
`default_nettype none
module ptec_pads (
    input  wire logic [31:0] padOut,
    input  wire logic [31:0] padOe,
    input  wire logic [31:0] extLevel,
    output logic      [31:0] padIn
);
    timeunit 1ns;
    timeprecision 1ns;
    // A pin shows the unit's drive where enabled, else the outside level.
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule
`default_nettype wire

// File: testbench/ptec_sva_sva.sv
// Checker: bus handshake, event pulses and wake outputs of the unit.
// Assumes it is bound to the unit and sees only its ports.
`default_nettype none
module ptec_sva (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic [7:0] eventInPulse,
    input wire logic       portEventPulse,
    input wire logic       systemOffReq,
    input wire logic       wakeReset,
    input wire logic       wakeLine
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Steps of one bus transfer.
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    property p_answer; s_setup |=> s_access; endproperty
    property p_readyPulse; pready |=> !pready; endproperty
    property p_errReady; pslverr |-> pready; endproperty
    property p_evPulse; (eventInPulse & $past(eventInPulse)) == 8'h00;
    endproperty
    property p_portRise; $rose(wakeLine) |-> portEventPulse; endproperty
    property p_portOnly; portEventPulse |-> wakeLine && !$past(wakeLine);
    endproperty
    property p_portPulse; portEventPulse |=> !portEventPulse; endproperty
    property p_wake;
        wakeReset == ($past(systemOffReq) && $past(wakeLine));
    endproperty
    a_answer: assert property (p_answer)
        else $error("No answer after a setup cycle.");
    a_readyPulse: assert property (p_readyPulse)
        else $error("Ready held longer than one cycle.");
    a_errReady: assert property (p_errReady)
        else $error("Error flag without ready.");
    a_evPulse: assert property (p_evPulse)
        else $error("Input event longer than one cycle.");
    a_portRise: assert property (p_portRise)
        else $error("Wake line rose without port event.");
    a_portOnly: assert property (p_portOnly)
        else $error("Port event without a wake line rise.");
    a_portPulse: assert property (p_portPulse)
        else $error("Port event longer than one cycle.");
    a_wake: assert property (p_wake)
        else $error("Wake reset does not follow off request.");
endmodule
`default_nettype wire

// File: testbench/pin_task_event_channels_bench.sv
// Self-checking bench for the pin task and event unit.
// Assumes the unit's source and its defines header are compiled first.
`default_nettype none
`include "pteu_defines.vh"
module pin_task_event_channels_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, sys_rst = 1'h1, systemOffReq = 1'h0;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, portOutValue = 32'h0, portDirOut = 32'h0;
    logic [31:0] extLevel = 32'h0, prdata, padIn, padOut, padOe, rd;
    logic [63:0] padSense = 64'h0;
    logic [7:0]  setT = 8'h0, clrT = 8'h0, outT = 8'h0, eventInPulse;
    logic        pready, pslverr, portEventPulse, wakeReset, wakeLine, err;
    int          failures = 0, num_checks = 0, evCnt = 0, portCnt = 0;
    pteu_pin_task_event_unit DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn),
        .portOutValue(portOutValue), .portDirOut(portDirOut),
        .padSense(padSense), .padOut(padOut), .padOe(padOe),
        .fabricSetTask(setT), .drive_low_task(clrT), .fabricOutTask(outT),
        .eventInPulse(eventInPulse), .portEventPulse(portEventPulse),
        .systemOffReq(systemOffReq), .wakeReset(wakeReset),
        .wakeLine(wakeLine));
    ptec_pads u_pads (.padOut(padOut), .padOe(padOe), .extLevel(extLevel),
        .padIn(padIn));
    // Clock and event counters.
    always #50 clk = ~clk;
    always @(posedge clk) begin
        evCnt <= evCnt + int'(eventInPulse[1]);
        portCnt <= portCnt + int'(portEventPulse);
    end
    task automatic results;
        $display("Checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bus transfer, held until ready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            failures++;
            $display("Error at %0t: no ready from the unit", $time);
            results();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
        tick(3);
    endtask
    task automatic strobe(input logic [7:0] s, c, o);
        @(posedge clk);
        setT <= s;
        clrT <= c;
        outT <= o;
        @(posedge clk);
        setT <= 8'h0;
        clrT <= 8'h0;
        outT <= 8'h0;
        tick(3);
    endtask
    task automatic pin5(input logic e);
        chk({31'h0, padOut[5]}, {31'h0, e});
    endtask
    // Main sequence of tests.
    initial begin
        tick(2);
        sys_rst <= 1'h0;
        portOutValue <= 32'ha5a5_0000;
        portDirOut <= 32'h0000_ffff;
        tick(4);
        chk(padOut, 32'ha5a5_0000);
        chk(padOe, 32'h0000_ffff);
        for (int i = 0; i < 8; i++)
            rdchk(12'h510 + 12'(4 * i), 32'h0);
        apb(1'h0, 12'h304, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(`PTEU_OFF_CFG, 32'hffff_ffff);
        rdchk(`PTEU_OFF_CFG, `PTEU_CFG_MASK);
        $display("Test registers done");
        wr(`PTEU_OFF_CFG, 32'h0013_0503);
        pin5(1'h1);
        chk({31'h0, padOe[5]}, 32'h1);
        wr(`PTEU_OFF_CLR, 32'h1);
        pin5(1'h0);
        portOutValue <= 32'hffff_ffff;
        wr(`PTEU_OFF_SET, 32'h1);
        pin5(1'h1);
        wr(`PTEU_OFF_OUT, 32'h1);
        pin5(1'h0);
        strobe(8'h1, 8'h1, 8'h1);
        pin5(1'h1);
        strobe(8'h1, 8'h1, 8'h0);
        pin5(1'h0);
        for (int p = 1; p < 3; p++) begin
            wr(`PTEU_OFF_CFG, 32'h0000_0503 | (32'(p) << 16)
               | (p == 2 ? 32'h0010_0000 : 32'h0));
            strobe(8'h0, 8'h0, 8'h1);
            pin5(p == 1);
        end
        wr(`PTEU_OFF_CFG, 32'h0010_0503);
        strobe(8'h1, 8'h1, 8'h1);
        pin5(1'h1);
        portOutValue <= 32'h0;
        strobe(8'h0, 8'h1, 8'h1);
        pin5(1'h1);
        wr(`PTEU_OFF_CFG, 32'h0);
        pin5(1'h0);
        $display("Test tasks done");
        for (int p = 1; p < 4; p++) begin
            wr(12'h514, 32'h0000_0901 | (32'(p) << 16));
            chk({31'h0, padOe[9]}, 32'h0);
            rd = 32'(evCnt);
            extLevel[9] <= 1'h1;
            tick(8);
            extLevel[9] <= 1'h0;
            tick(8);
            chk(32'(evCnt) - rd, p == 3 ? 32'h2 : 32'h1);
        end
        rdchk(12'h104, 32'h1);
        wr(12'h104, 32'h0);
        rdchk(12'h104, 32'h0);
        $display("Test events done");
        padSense <= 64'h0000_0200_0000_0000;
        extLevel[20] <= 1'h1;
        tick(8);
        chk({31'h0, wakeLine}, 32'h1);
        chk(32'(portCnt), 32'h1);
        rdchk(`PTEU_OFF_EVPORT, 32'h1);
        wr(`PTEU_OFF_EVPORT, 32'h0);
        rdchk(`PTEU_OFF_EVPORT, 32'h0);
        systemOffReq <= 1'h1;
        tick(3);
        chk({31'h0, wakeReset}, 32'h1);
        systemOffReq <= 1'h0;
        padSense <= 64'h0000_0300_0000_0000;
        extLevel[20] <= 1'h0;
        tick(8);
        chk(32'(portCnt), 32'h2);
        wr(`PTEU_OFF_WAKESEL, 32'h1);
        chk(32'(portCnt), 32'h2);
        wr(`PTEU_OFF_LATCH, 32'hffff_ffff);
        chk(32'(portCnt), 32'h3);
        rdchk(`PTEU_OFF_LATCH, 32'h0010_0000);
        chk({31'h0, wakeLine}, 32'h1);
        $display("Test port event done");
        results();
    end
endmodule
bind pteu_pin_task_event_unit ptec_sva u_sva (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .eventInPulse(eventInPulse), .portEventPulse(portEventPulse),
    .systemOffReq(systemOffReq), .wakeReset(wakeReset), .wakeLine(wakeLine));
`default_nettype wire
